// *** dv/tb_top.sv ***
// self-checking bench of the watchdog/alarm control block
// assumes wdc_board_model provides the oscillator and the reset wire
`timescale 1ns/100ps
module tb_top;
   import wdc_pkg::*;
   localparam int P = 40;
   localparam int S = 20;
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic rst = 1'b1;
   logic busReq = 1'b0;
   wdc_req_type busReqData = '0;
   logic powerFail = 1'b0;
   logic onBackup = 1'b0;
   logic irqControl = 1'b1;
   logic buttonDown = 1'b0;
   logic alertSel = 1'b0;
   int lowCnt = 0;
   logic busDone, busAcked, oscClkIn, resetPinIn, resetPinOeN, alertPinOeN, squareWaveOeN;
   logic oscEnable, chargerOn, chargerDiode, busBusy, resetPinOut, alertPinOut, squareWaveOut;
   logic [1:0] chargerRes;
   logic [7:0] busRdata;
   int fails = 0;
   int tests_run = 0;
   wire pinSel = alertSel ? alertPinOeN : resetPinOeN;
   logic [7:0] chg [10] = '{8'hA5, 8'hA6, 8'hA7, 8'hA9, 8'hAA, 8'hAB, 8'hA4, 8'hA1, 8'hAD, 8'h55};
   logic [1:0] rates [3] = '{2'h3, 2'h2, 2'h1};
   int rises [3] = '{64, 16, 8};

   initial forever #20 clk = ~clk;
   initial begin
      #1.3;
      forever #3 linkClk = ~linkClk;
   end

   wdc_core #(.PULSE_CYCLES(P), .START_CYCLES(S)) DUT (.clk, .rst, .linkClk, .busReq,
      .busReqData, .busBusy, .busDone, .busAcked, .busRdata, .powerFail, .onBackup,
      .irqControl, .oscClkIn, .resetPinIn, .resetPinOut, .resetPinOeN, .alertPinOut,
      .alertPinOeN, .squareWaveOut, .squareWaveOeN, .oscEnable, .chargerOn, .chargerDiode,
      .chargerRes);
   wdc_board_model board (.clk, .buttonDown, .resetPinOeN, .resetPinIn, .oscClkIn);

   always @(negedge clk) if (resetPinOeN === 1'b0) lowCnt++;

   task automatic print_verdict();
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chkLen(input string name, input int lo, input int hi, input int got);
      tests_run++;
      if (got < lo || got > hi) begin
         fails++;
         $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask
   // one-cycle request, held answer sampled between link edges
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] rd, output logic ack);
      int n;
      n = 0;
      @(negedge linkClk);
      busReq = 1'b1;
      busReqData = {w, a, d};
      @(negedge linkClk);
      busReq = 1'b0;
      chk("bus busy", 8'h01, {7'h00, busBusy});
      while (busDone !== 1'b1 && n < 300) begin
         @(negedge linkClk);
         n++;
      end
      rd = busRdata;
      ack = busAcked;
      if (n >= 300) begin
         fails++;
         $display("[ERR] busDone expected 1 seen %b", busDone);
         print_verdict();
      end
      @(negedge linkClk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] rd;
      logic ack;
      acc(1'b1, a, d, rd, ack);
      chk("write ack", 8'h01, {7'h00, ack});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] rd;
      logic ack;
      acc(1'b0, a, 8'h00, rd, ack);
      chk("read ack", 8'h01, {7'h00, ack});
      chk($sformatf("reg %h", a), exp, rd);
   endtask
   task automatic refused(input logic [7:0] a);
      logic [7:0] rd;
      logic ack;
      acc(1'b0, a, 8'h00, rd, ack);
      chk("refused ack", 8'h00, {7'h00, ack});
   endtask
   task automatic waitPin(input logic al, input logic lvl, input int lim);
      int n;
      n = 0;
      alertSel = al;
      // select the pin directly: the wire would still show the previous choice here
      while ((al ? alertPinOeN : resetPinOeN) !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         fails++;
         $display("[ERR] pin expected %b seen %b", lvl, pinSel);
         print_verdict();
      end
   endtask
   task automatic lowLen(input logic al, output int n);
      n = 0;
      alertSel = al;
      while ((al ? alertPinOeN : resetPinOeN) === 1'b0 && n < 5000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic riseCnt(input int cyc, output int r);
      logic prev;
      r = 0;
      prev = squareWaveOeN;
      repeat (cyc) begin
         @(negedge clk);
         if (squareWaveOeN === 1'b1 && prev === 1'b0) r++;
         prev = squareWaveOeN;
      end
   endtask

   initial begin
      int n;
      logic [7:0] c;
      logic on;
      int r;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (10) @(negedge clk);
      rdc(A_CTRL, 8'h06);
      rdc(A_CHG, 8'h00);
      rdc(A_FLAGS, 8'h80);
      wr(A_FLAGS, 8'h00);
      rdc(A_FLAGS, 8'h00);
      wr(A_CNT0, 8'h5A);
      wr(8'h05, 8'hC3);
      wr(A_CNT2, 8'h81);
      repeat (300) @(negedge clk);
      rdc(A_CNT0, 8'h5A);
      rdc(8'h05, 8'hC3);
      rdc(A_CNT2, 8'h81);
      rdc(8'h0A, 8'h00);
      for (n = 0; n < 10; n++) begin
         c = chg[n];
         on = c[7:4] == 4'hA && (c[3:2] == 2'h1 || c[3:2] == 2'h2) && c[1:0] != 2'h0;
         wr(A_CHG, c);
         repeat (5) @(negedge clk);
         chk("charger", {4'h0, on, on & c[3], on ? c[1:0] : 2'h0},
            {4'h0, chargerOn, chargerOn & chargerDiode, chargerRes});
      end
      for (n = 0; n < 3; n++) begin
         wr(A_CTRL, {5'h00, rates[n], 1'b0});
         riseCnt(512, r);
         chkLen("square rises", rises[n] - 1, rises[n] + 1, r);
      end
      wr(A_CTRL, 8'h66);
      wr(A_CNT0, 8'h00);
      wr(8'h05, 8'h00);
      wr(A_CNT2, 8'h00);
      r = lowCnt;
      repeat (1000) @(negedge clk);
      rdc(A_FLAGS, 8'h00);
      wr(A_CTRL, 8'h06);
      wr(A_CNT0, 8'h20);
      wr(A_CTRL, 8'h66);
      for (n = 0; n < 5; n++) begin
         repeat (1000) @(negedge clk);
         acc(1'b0, A_CNT0, 8'h00, c, on);
      end
      chkLen("serviced reset", r, r, lowCnt);
      waitPin(1'b0, 1'b0, 3000);
      chk("pin drive", 8'h00, {5'h00, resetPinOut, alertPinOut, squareWaveOut});
      fork
         lowLen(1'b0, n);
         refused(A_FLAGS);
      join
      chkLen("reset pulse", P, P + 3, n);
      rdc(A_FLAGS, 8'h00);
      wr(A_CTRL, 8'h06);
      wr(A_CNT0, 8'h04);
      wr(A_CTRL, 8'h6F);
      waitPin(1'b1, 1'b0, 1000);
      fork
         lowLen(1'b1, n);
         begin
            wr(A_FLAGS, 8'h00);
            wr(A_CTRL, 8'h6E);
         end
      join
      chkLen("alert pulse", P, P + 3, n);
      rdc(A_FLAGS, 8'h00);
      wr(A_CTRL, 8'h06);
      wr(A_CNT0, 8'h02);
      wr(A_CTRL, 8'h6E);
      repeat (600) @(negedge clk);
      rdc(A_FLAGS, 8'h01);
      chk("alert idle", 8'h01, {7'h00, alertPinOeN});
      wr(A_CTRL, 8'h47);
      repeat (10) @(negedge clk);
      chk("alert level", 8'h00, {7'h00, alertPinOeN});
      wr(A_FLAGS, 8'h01);
      repeat (10) @(negedge clk);
      chk("alert kept", 8'h00, {7'h00, alertPinOeN});
      irqControl = 1'b0;
      repeat (10) @(negedge clk);
      chk("alert masked", 8'h01, {7'h00, alertPinOeN});
      irqControl = 1'b1;
      wr(A_CTRL, 8'h06);
      wr(A_CTRL, 8'h66);
      waitPin(1'b0, 1'b0, 30);
      waitPin(1'b0, 1'b1, P + 20);
      rdc(A_FLAGS, 8'h00);
      wr(A_CTRL, 8'h06);
      buttonDown = 1'b1;
      waitPin(1'b0, 1'b0, 20);
      refused(A_CTRL);
      waitPin(1'b0, 1'b1, P + 20);
      repeat (3 * P) @(negedge clk);
      chk("button wait", 8'h01, {7'h00, resetPinOeN});
      buttonDown = 1'b0;
      waitPin(1'b0, 1'b0, 20);
      lowLen(1'b0, n);
      chkLen("release pulse", P - 2, P + 3, n);
      powerFail = 1'b1;
      waitPin(1'b0, 1'b0, 10);
      repeat (50) @(negedge clk);
      refused(A_CTRL);
      powerFail = 1'b0;
      lowLen(1'b0, n);
      chkLen("power reset", P, P + 6, n);
      onBackup = 1'b1;
      // let the backup level pass the synchroniser so its own edge is not counted
      repeat (5) @(negedge clk);
      riseCnt(200, r);
      chkLen("square floats", 0, 0, r);
      wr(A_CTRL, 8'h16);
      riseCnt(512, r);
      chkLen("backup square", 63, 65, r);
      wr(A_CTRL, 8'h86);
      repeat (10) @(negedge clk);
      chk("osc stopped", 8'h00, {7'h00, oscEnable});
      onBackup = 1'b0;
      repeat (10) @(negedge clk);
      chk("osc on mains", 8'h01, {7'h00, oscEnable});
      rdc(A_FLAGS, 8'h80);
      powerFail = 1'b1;
      repeat (20) @(negedge clk);
      powerFail = 1'b0;
      lowLen(1'b0, n);
      chkLen("power reset osc", P + S, P + S + 6, n);
      print_verdict();
   end
endmodule // tb_top

// *** dv/wdc_board_model.sv ***
// board around the device: a sped-up oscillator and the open-drain reset wire
// assumes the bench moves buttonDown; the reset wire has a pull-up
`timescale 1ns/100ps
module wdc_board_model (
   input wire logic clk,
   input wire logic buttonDown,
   input wire logic resetPinOeN,
   output logic resetPinIn,
   output logic oscClkIn
);
   int div = 0;
   logic osc = 1'b0;
   // period of 8 core clocks so that fast-mode expiries fit in a short run
   always @(negedge clk) begin
      div <= (div == 3) ? 0 : div + 1;
      if (div == 3) begin
         osc <= ~osc;
      end
   end
   assign oscClkIn = osc;
   // pull-up unless the device or the pushbutton pulls low
   assign resetPinIn = ~(~resetPinOeN | buttonDown);
endmodule // wdc_board_model

// *** hw/wdc_core.sv ***
// watchdog/alarm counter, reset sequencing, square wave and charger decode
// assumes a serial protocol engine on linkClk presenting one register access at a time
`timescale 1ns/100ps
module wdc_core import wdc_pkg::*; #(
   parameter int PULSE_CYCLES = PULSE_CYC,
   parameter int START_CYCLES = OSC_START_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic linkClk,
   input wire logic busReq,
   input wire wdc_req_type busReqData,
   output logic busBusy,
   output logic busDone,
   output logic busAcked,
   output logic [7:0] busRdata,
   input wire logic powerFail,
   input wire logic onBackup,
   input wire logic irqControl,
   input wire logic oscClkIn,
   input wire logic resetPinIn,
   output logic resetPinOut,
   output logic resetPinOeN,
   output logic alertPinOut,
   output logic alertPinOeN,
   output logic squareWaveOut,
   output logic squareWaveOeN,
   output logic oscEnable,
   output logic chargerOn,
   output logic chargerDiode,
   output logic [1:0] chargerRes
);
   // link side: a request is held in req_q until the core answers
   wdc_req_type req_q;
   logic reqTgl_q, busy_q, done_q, acked_q, ackSeen_q;
   logic [1:0] ackSy_q;
   logic [7:0] rdata_q;
   logic ackTgl_q, resAck_q;
   logic [7:0] resData_q;
   wire linkAckEdge = ackSy_q[1] ^ ackSeen_q;

   always_ff @(posedge linkClk or posedge rst) begin
      if (rst) begin
         req_q <= '0;
         reqTgl_q <= 1'b0;
         busy_q <= 1'b0;
         ackSy_q <= 2'h0;
         ackSeen_q <= 1'b0;
         done_q <= 1'b0;
         acked_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ackSy_q <= {ackSy_q[0], ackTgl_q};
         ackSeen_q <= ackSy_q[1];
         done_q <= linkAckEdge;
         if (busReq && !busy_q) begin
            req_q <= busReqData;
            reqTgl_q <= ~reqTgl_q;
            busy_q <= 1'b1;
         end else if (linkAckEdge) begin
            busy_q <= 1'b0;
         end
         // result words are stable since the toggle left the core
         if (linkAckEdge) begin
            acked_q <= resAck_q;
            rdata_q <= resData_q;
         end
      end
   end
   assign busBusy = busy_q;
   assign busDone = done_q;
   assign busAcked = acked_q;
   assign busRdata = rdata_q;

   // core side synchronisers
   logic [1:0] reqSy_q;
   logic reqSeen_q;
   logic [SY_N-1:0] pinA_q, pinB_q, pinPrev_q;
   wire [SY_N-1:0] pinsIn = {irqControl, oscClkIn, resetPinIn, onBackup, powerFail};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reqSy_q <= 2'h0;
         reqSeen_q <= 1'b0;
         pinA_q <= '0;
         pinB_q <= '0;
         pinPrev_q <= '0;
      end else begin
         reqSy_q <= {reqSy_q[0], reqTgl_q};
         reqSeen_q <= reqSy_q[1];
         pinA_q <= pinsIn;
         pinB_q <= pinA_q;
         pinPrev_q <= pinB_q;
      end
   end
   wire reqEdge = reqSy_q[1] ^ reqSeen_q;
   wire pf = pinB_q[SY_PF];
   wire bat = pinB_q[SY_BAT];
   wire irqOn = pinB_q[SY_IRQ];
   wire pinHi = pinB_q[SY_RST];
   wire pinFall = pinPrev_q[SY_RST] & ~pinHi;
   wire pinRise = ~pinPrev_q[SY_RST] & pinHi;
   wire oscEdge = pinB_q[SY_OSC] & ~pinPrev_q[SY_OSC];

   // registers
   wdc_ctrl_type ctrl_q;
   wdc_chg_type chg_q;
   wdc_rst_type state_q;
   logic [23:0] cnt_q, seed_q, cntD;
   logic [31:0] sec_q;
   logic [DIV_W-1:0] div_q;
   logic af_q, osf_q, afD, osfD;
   logic alertPulse_q, pend_q, srcWd_q, srcBtn_q;
   logic [TMR_W-1:0] timer_q, alertTmr_q;

   wire oscRun = ~(ctrl_q.oscDisable & bat);
   wire tick1 = oscRun & oscEdge & (&div_q);
   wire tick4k = oscRun & oscEdge & (&div_q[2:0]);
   wire accessOk = (state_q == RS_IDLE) & ~pf;
   wire acc = reqEdge & accessOk;
   wire accWr = acc & req_q.write;
   wire accRd = acc & ~req_q.write;
   wire isCnt = (req_q.addr >= A_CNT0) && (req_q.addr <= A_CNT2);
   wire [1:0] cntIdx = req_q.addr[1:0] - A_CNT0[1:0];
   wire [1:0] secIdx = req_q.addr[1:0];
   wire isSec = req_q.addr < A_CNT0;
   wire wrCtrl = accWr && req_q.addr == A_CTRL;
   wire wrFlags = accWr && req_q.addr == A_FLAGS;
   wire fast = ctrl_q.fastWatchdogMode;
   wire running = ctrl_q.countdownEnable && cnt_q != 24'h000000;
   wire tickSel = fast ? tick4k : tick1;
   wire expire = running & tickSel & (cnt_q == 24'h000001) & ~(acc & isCnt);
   wire alertEnd = alertPulse_q && alertTmr_q == TMR_W'(1);
   wire wdEnd = state_q == RS_DRIVE && srcWd_q && timer_q == TMR_W'(1) && !pf;
   wire wrEnable = wrCtrl & req_q.data[6] & ~ctrl_q.countdownEnable;
   wire r7Fire = wrEnable & af_q & req_q.data[5];
   wire wdFire = (expire & fast) | r7Fire;
   wire steerSel = wrCtrl ? req_q.data[3] : ctrl_q.resetSteer;
   wire aieSel = wrCtrl ? req_q.data[0] : ctrl_q.alarmIrqEnable;
   wire startAlert = wdFire & steerSel & aieSel & irqOn;
   wire [TMR_W-1:0] loadPulse = TMR_W'(PULSE_CYCLES);
   wire [TMR_W-1:0] loadPwr = ctrl_q.oscDisable ? TMR_W'(PULSE_CYCLES + START_CYCLES)
                                                : loadPulse;

   logic [23:0] seedWr;
   logic [31:0] secWr;
   always_comb begin
      seedWr = seed_q;
      seedWr[cntIdx*8 +: 8] = req_q.data;
      secWr = sec_q;
      secWr[secIdx*8 +: 8] = req_q.data;
   end

   always_comb begin
      cntD = cnt_q;
      if (accWr && isCnt) begin
         cntD = (alertPulse_q && !alertEnd) ? cnt_q : seedWr;
      end else if (accRd && isCnt && running) begin
         cntD = seed_q;
      end else if (alertEnd && pend_q) begin
         cntD = seed_q;
      end else if (expire) begin
         cntD = fast ? 24'h000000 : seed_q;
      end else if (running && tickSel) begin
         cntD = cnt_q - 24'h000001;
      end
   end

   // hardware set wins over a host clear in the same cycle
   always_comb begin
      afD = af_q;
      if (wrFlags && !req_q.data[FLG_AF]) afD = 1'b0;
      if (alertEnd || wdEnd) afD = 1'b0;
      if (expire) afD = 1'b1;
      osfD = osf_q;
      if (wrFlags && !req_q.data[FLG_OSF]) osfD = 1'b0;
      if (!oscRun) osfD = 1'b1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 24'h000000;
         seed_q <= 24'h000000;
         sec_q <= 32'h00000000;
         af_q <= 1'b0;
         osf_q <= 1'b1;
         div_q <= '0;
      end else begin
         cnt_q <= cntD;
         af_q <= afD;
         osf_q <= osfD;
         if (accWr && isCnt) seed_q <= seedWr;
         if (accWr && isSec) sec_q <= secWr;
         else if (tick1) sec_q <= sec_q + 32'h00000001;
         if (oscRun && oscEdge) div_q <= div_q + DIV_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
         chg_q <= CHG_RST;
      end else begin
         if (wrCtrl) ctrl_q <= req_q.data;
         if (accWr && req_q.addr == A_CHG) chg_q <= req_q.data;
      end
   end

   // reset pin sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= RS_IDLE;
         timer_q <= '0;
         srcWd_q <= 1'b0;
         srcBtn_q <= 1'b0;
      end else if (pf) begin
         state_q <= RS_DRIVE;
         timer_q <= loadPwr;
         srcWd_q <= 1'b0;
         srcBtn_q <= 1'b0;
      end else begin
         unique case (state_q)
            RS_IDLE: begin
               if (pinFall) begin
                  state_q <= RS_DRIVE;
                  timer_q <= loadPulse;
                  srcBtn_q <= 1'b1;
                  srcWd_q <= 1'b0;
               end else if (wdFire && !steerSel) begin
                  state_q <= RS_DRIVE;
                  timer_q <= loadPulse;
                  srcWd_q <= 1'b1;
                  srcBtn_q <= 1'b0;
               end
            end
            RS_DRIVE: begin
               if (timer_q == TMR_W'(1)) begin
                  state_q <= srcBtn_q ? RS_CHECK : RS_IDLE;
                  timer_q <= TMR_W'(SETTLE_CYC);
                  srcWd_q <= 1'b0;
               end else begin
                  timer_q <= timer_q - TMR_W'(1);
               end
            end
            RS_CHECK: begin
               // let the released pin pass the synchroniser before judging it
               if (timer_q == TMR_W'(1)) begin
                  state_q <= pinHi ? RS_IDLE : RS_WAIT;
               end else begin
                  timer_q <= timer_q - TMR_W'(1);
               end
            end
            RS_WAIT: begin
               if (pinRise) begin
                  state_q <= RS_DRIVE;
                  timer_q <= loadPulse;
                  srcBtn_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // alert pulse: host clears of the flag or enable do not cut it short
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alertPulse_q <= 1'b0;
         alertTmr_q <= '0;
         pend_q <= 1'b0;
      end else begin
         if (startAlert && !alertPulse_q) begin
            alertPulse_q <= 1'b1;
            alertTmr_q <= loadPulse;
         end else if (alertPulse_q) begin
            if (alertEnd) alertPulse_q <= 1'b0;
            alertTmr_q <= alertTmr_q - TMR_W'(1);
         end
         // a write in the last pulse cycle loads directly, so it must not leave a pending reload
         if (accWr && isCnt && alertPulse_q && !alertEnd) pend_q <= 1'b1;
         else if (alertEnd) pend_q <= 1'b0;
      end
   end

   // register read view and the answer toward the link
   wire [7:0] regView [10];
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sec
         assign regView[gi] = sec_q[gi*8 +: 8];
      end
      for (gi = 0; gi < 3; gi++) begin : g_cnt
         assign regView[gi+4] = cnt_q[gi*8 +: 8];
      end
   endgenerate
   assign regView[7] = ctrl_q;
   assign regView[8] = {osf_q, 6'h00, af_q};
   assign regView[9] = chg_q;
   wire [7:0] rdByte = (req_q.addr <= A_CHG) ? regView[req_q.addr[3:0]] : 8'h00;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ackTgl_q <= 1'b0;
         resAck_q <= 1'b0;
         resData_q <= 8'h00;
      end else if (reqEdge) begin
         ackTgl_q <= ~ackTgl_q;
         resAck_q <= accessOk;
         resData_q <= accRd ? rdByte : 8'h00;
      end
   end

   // pins and analog controls
   wire alertLevel = ~fast & af_q & ctrl_q.alarmIrqEnable & irqOn;
   wire sqOn = oscRun & (~bat | ctrl_q.backupWaveEnable);
   wire sqLevel = (ctrl_q.rateSel == RATE_1HZ) ? div_q[SQ_1HZ_BIT] :
                  (ctrl_q.rateSel == RATE_4K) ? div_q[SQ_4K_BIT] :
                  (ctrl_q.rateSel == RATE_8K) ? div_q[SQ_8K_BIT] : pinB_q[SY_OSC];
   wire chgValid = chg_q.chargerKey == CHG_KEY
                   && (chg_q.diodeSelect == DIODE_NONE || chg_q.diodeSelect == DIODE_ONE)
                   && chg_q.chargeResistorSel != RES_OFF;
   logic rstOeN_q, alertOeN_q, sqOeN_q, oscEn_q, chgOn_q, chgDiode_q, low_q;
   logic [1:0] chgRes_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rstOeN_q <= 1'b0;
         alertOeN_q <= 1'b1;
         sqOeN_q <= 1'b1;
         oscEn_q <= 1'b1;
         chgOn_q <= 1'b0;
         chgDiode_q <= 1'b0;
         chgRes_q <= RES_OFF;
         low_q <= 1'b0;
      end else begin
         rstOeN_q <= ~(state_q == RS_DRIVE);
         alertOeN_q <= ~(alertPulse_q | alertLevel);
         sqOeN_q <= ~(sqOn & ~sqLevel);
         oscEn_q <= oscRun;
         chgOn_q <= chgValid;
         chgDiode_q <= chgValid & (chg_q.diodeSelect == DIODE_ONE);
         chgRes_q <= chgValid ? chg_q.chargeResistorSel : RES_OFF;
         low_q <= 1'b0;
      end
   end
   assign resetPinOut = low_q;
   assign alertPinOut = low_q;
   assign squareWaveOut = low_q;
   assign resetPinOeN = rstOeN_q;
   assign alertPinOeN = alertOeN_q;
   assign squareWaveOeN = sqOeN_q;
   assign oscEnable = oscEn_q;
   assign chargerOn = chgOn_q;
   assign chargerDiode = chgDiode_q;
   assign chargerRes = chgRes_q;

   chk_seed_write: assert property (
      @(posedge clk) disable iff (rst)
      accWr && isCnt && cntIdx == 2'h0 |=> seed_q[7:0] == $past(req_q.data))
      else $error("seed byte not loaded by counter write");
   chk_read_capture: assert property (
      @(posedge clk) disable iff (rst)
      accRd && isCnt && cntIdx == 2'h1 |=> resData_q == $past(cnt_q[15:8]))
      else $error("read did not capture live count");
   chk_idle_storage: assert property (
      @(posedge clk) disable iff (rst)
      !ctrl_q.countdownEnable && !acc && !(alertEnd && pend_q) |=> $stable(cnt_q))
      else $error("disabled counter changed");
   chk_zero_stays: assert property (
      @(posedge clk) disable iff (rst)
      cnt_q == 24'h000000 && !(accWr && isCnt) && !alertEnd |=> cnt_q == 24'h000000 && !$rose(af_q))
      else $error("zero counter moved or flagged");
   chk_slow_reload: assert property (
      @(posedge clk) disable iff (rst)
      expire && !fast |=> af_q && cnt_q == seed_q)
      else $error("slow expiry did not reload");
   chk_fast_stop: assert property (
      @(posedge clk) disable iff (rst)
      expire && fast |=> af_q && cnt_q == 24'h000000 ##1 cnt_q == 24'h000000)
      else $error("fast expiry did not stop");
   chk_wd_reset: assert property (
      @(posedge clk) disable iff (rst)
      state_q == RS_IDLE && !pf && !pinFall && expire && fast && !ctrl_q.resetSteer
      |=> state_q == RS_DRIVE && srcWd_q ##1 !resetPinOeN)
      else $error("fast expiry missed reset pulse");
   chk_alert_hold: assert property (
      @(posedge clk) disable iff (rst)
      alertPulse_q && !alertEnd |=> alertPulse_q ##1 !alertPinOeN)
      else $error("alert pulse cut short");
   chk_flag_sticky: assert property (
      @(posedge clk) disable iff (rst)
      wrFlags && req_q.data[FLG_AF] && !alertEnd && !wdEnd |=> af_q || !$past(af_q))
      else $error("writing one cleared the alarm flag");
   chk_power_hold: assert property (
      @(posedge clk) disable iff (rst)
      pf [*2] |=> !resetPinOeN && !acc)
      else $error("power fail did not hold reset");
   chk_refuse_access: assert property (
      @(posedge clk) disable iff (rst)
      reqEdge && state_q != RS_IDLE |=> !resAck_q && $stable(ctrl_q))
      else $error("access taken during reset cycle");
endmodule // wdc_core

// *** inc/wdc_pkg.sv ***
// constants, field layouts and carrier types of the watchdog/alarm control block
// assumes a 25 MHz core clock and a 32.768 kHz oscillator level sampled on it
// Operation
// - 24-bit down counter at bytes 04h-06h
// - counter write loads counter and seed
// - counter read captures count, counting continues
// - disabled counter is plain read/write storage
// - all-zero write keeps counter stopped, no flag
// - slow mode: 1 Hz, flag, reload, continue
// - flag set at enable in fast mode fires chosen output
// - fast mode: 4096 Hz, flag, then stop
// - fast expiry steer 0: reset pin pulse
// - fast expiry steer 1: alert pulse, uncuttable
// - counter write in pulse waits; end clears flag
// - any counter access before expiry reloads it
// - power fail holds reset, then 250 ms
// - oscillator disabled adds start-up time
// - pushbutton falling edge: 250 ms, await release
// - pushbutton release: another 250 ms low
// - osc_disable stops oscillator on backup only
// - backup_wave_enable keeps square wave on battery
// - rate bits pick square wave, reset 11
// - flag reaches alert pin only when enabled
// - charger on only for valid key codes
// - undefined power-up contents, no assumption
// - repeating alert stays low until flag cleared
// - oscillator stop flag sticky until written 0
package wdc_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int PULSE_MS = 250;
   localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
   localparam int OSC_START_MS = 1000;
   localparam int OSC_START_CYC = CLK_HZ / 1000 * OSC_START_MS;
   localparam int SETTLE_CYC = 4;
   localparam int TMR_W = 26;
   localparam int DIV_W = 15;
   localparam int SQ_1HZ_BIT = 14;
   localparam int SQ_8K_BIT = 1;
   localparam int SQ_4K_BIT = 2;
   localparam logic [7:0] A_SEC0 = 8'h00;
   localparam logic [7:0] A_CNT0 = 8'h04;
   localparam logic [7:0] A_CNT2 = 8'h06;
   localparam logic [7:0] A_CTRL = 8'h07;
   localparam logic [7:0] A_FLAGS = 8'h08;
   localparam logic [7:0] A_CHG = 8'h09;
   localparam logic [7:0] CTRL_RST = 8'h06;
   localparam logic [7:0] CHG_RST = 8'h00;
   localparam int FLG_OSF = 7;
   localparam int FLG_AF = 0;
   localparam logic [3:0] CHG_KEY = 4'hA;
   localparam logic [1:0] DIODE_NONE = 2'h1;
   localparam logic [1:0] DIODE_ONE = 2'h2;
   localparam logic [1:0] RES_OFF = 2'h0;
   localparam logic [1:0] RATE_1HZ = 2'h0;
   localparam logic [1:0] RATE_4K = 2'h1;
   localparam logic [1:0] RATE_8K = 2'h2;
   localparam int SY_PF = 0;
   localparam int SY_BAT = 1;
   localparam int SY_RST = 2;
   localparam int SY_OSC = 3;
   localparam int SY_IRQ = 4;
   localparam int SY_N = 5;
   typedef struct packed {
      logic oscDisable;
      logic countdownEnable;
      logic fastWatchdogMode;
      logic backupWaveEnable;
      logic resetSteer;
      logic [1:0] rateSel;
      logic alarmIrqEnable;
   } wdc_ctrl_type;
   typedef struct packed {
      logic [3:0] chargerKey;
      logic [1:0] diodeSelect;
      logic [1:0] chargeResistorSel;
   } wdc_chg_type;
   typedef struct packed {
      logic write;
      logic [7:0] addr;
      logic [7:0] data;
   } wdc_req_type;
   typedef enum logic [1:0] {
      RS_IDLE = 2'b00,
      RS_DRIVE = 2'b01,
      RS_CHECK = 2'b11,
      RS_WAIT = 2'b10
   } wdc_rst_type;
endpackage
